/* File: shared/dup_pkg.sv */
// package for the dual uart host bus port: constants, states and overview
// Overview of operation
// - strap high separate strobes, low read/write line
// - three address bits choose channel register
// - read strobe fall fetches byte, drives bus
// - write strobe fall opens, rise loads byte
// - read/write-line style ignores read strobe
// - write strobe is direction: high read, low write
// - first select enables channel a only
// - second select enables channel b only
// - read/write-line style: first select is chip select
// - second select picks channel: low a, high b
// - enable set: interrupt driven, general output low
// - enable clear: interrupt floats, general output high
// - read/write-line: channel a pin open-drain device irq
// - read/write-line: channel b interrupt held low
package dup_pkg;
    localparam int          DATA_W          = 8;     // data bus width
    localparam int          ADDR_W          = 3;     // register select width
    localparam logic        STYLE_SEPARATE  = 1'b1;  // strap level for separate strobes
    localparam logic        CHAN_A          = 1'b0;  // channel code for a
    localparam logic        CHAN_B          = 1'b1;  // channel code for b
    localparam logic [7:0]  DATA_RESET      = 8'h00; // data and write latches after reset
    localparam logic [2:0]  ADDR_RESET      = 3'h0;  // address latch after reset
    localparam logic        GENERAL_RESET   = 1'b1;  // general output idles high

    // access sequencer states, gray along idle-fetch-drive and idle-write
    typedef enum logic [1:0] {
        DUP_IDLE       = 2'b00,
        DUP_READ_FETCH = 2'b01,
        DUP_READ_DRIVE = 2'b11,
        DUP_WRITE_OPEN = 2'b10
    } dup_state_type;
endpackage : dup_pkg

/* File: rtl/dup_irq_pin.sv */
// one channel interrupt pin driver with its companion general output
`timescale 1ns/10ps
module dup_irq_pin (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic separate_style,   // strap, high for separate strobes
    input  wire logic is_channel_a,     // this instance serves channel a
    input  wire logic irq_in,           // active-high request to present
    input  wire logic ioe,              // interrupt output enable bit
    output logic      pin_out,          // pin level when driven
    output logic      pin_oe,           // high while the pin is driven
    output logic      general_out       // companion general output
);
    // next values per style
    wire next_out = separate_style ? irq_in : 1'b0;
    wire next_oe  = separate_style ? ioe : (is_channel_a ? irq_in : 1'b1);

    // registered so the pins never glitch on decode hazards
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_out     <= 1'b0;
            pin_oe      <= 1'b0;
            general_out <= dup_pkg::GENERAL_RESET;
        end
        else
        begin
            pin_out     <= next_out;
            pin_oe      <= next_oe;
            general_out <= ~ioe;
        end
    end

    property p_irq_on;
        @(posedge mclk) disable iff (!rst_n)
        (separate_style && ioe) |=> (pin_oe && !general_out && pin_out == $past(irq_in));
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("enabled irq not driven");

    property p_irq_off;
        @(posedge mclk) disable iff (!rst_n)
        (separate_style && !ioe) |=> (!pin_oe && general_out);
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("disabled irq not floating");

    property p_open_drain;
        @(posedge mclk) disable iff (!rst_n)
        (!separate_style && is_channel_a) |=> (!pin_out && pin_oe == $past(irq_in));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain irq wrong");

    property p_b_low;
        @(posedge mclk) disable iff (!rst_n)
        (!separate_style && !is_channel_a) |=> (!pin_out && pin_oe);
    endproperty
    a_b_low: assert property (p_b_low) else $error("channel b irq not held low");
endmodule : dup_irq_pin

/* File: rtl/dup_host_port.sv */
// host bus port of the dual uart: strobe decode, access sequencing, irq pins
`timescale 1ns/10ps
module dup_host_port (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       bus_style,            // strap
    input  wire logic [dup_pkg::ADDR_W-1:0] addr,                 // register select
    input  wire logic                       read_strobe_n,
    input  wire logic                       write_strobe_n,       // also direction line
    input  wire logic                       channel_a_select_n,
    input  wire logic                       channel_b_select_n,   // also channel bit
    input  wire logic [dup_pkg::DATA_W-1:0] data_in,              // data bus, pin side
    output logic      [dup_pkg::DATA_W-1:0] data_out,
    output logic                            data_oe,              // high while driving bus
    output logic                            reg_read,             // one-cycle fetch request
    output logic                            reg_write,            // one-cycle load request
    output logic                            reg_channel,          // 0 a, 1 b
    output logic      [dup_pkg::ADDR_W-1:0] reg_addr,
    output logic      [dup_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [dup_pkg::DATA_W-1:0] reg_rdata,            // valid while reg_read
    input  wire logic                       channel_a_irq,        // internal requests
    input  wire logic                       channel_b_irq,
    input  wire logic                       channel_a_ioe,        // output enable bits
    input  wire logic                       channel_b_ioe,
    output logic                            channel_a_interrupt,
    output logic                            channel_a_interrupt_oe,
    output logic                            channel_b_interrupt,
    output logic                            channel_b_interrupt_oe,
    output logic                            channel_a_general_output,
    output logic                            channel_b_general_output
);
    dup_pkg::dup_state_type state;          // access sequencer
    dup_pkg::dup_state_type next_state;

    // style decode
    wire separate = (bus_style == dup_pkg::STYLE_SEPARATE);
    // separate style: exactly one select low; both low is treated as no access
    wire sep_sel  = channel_a_select_n ^ channel_b_select_n;
    wire sep_chan = channel_a_select_n ? dup_pkg::CHAN_B : dup_pkg::CHAN_A;
    // read/write-line style: one chip select, second select is channel bit
    wire rw_sel   = !channel_a_select_n;
    wire rw_chan  = channel_b_select_n;
    wire selected = separate ? sep_sel : rw_sel;
    wire access_chan = separate ? sep_chan : rw_chan;
    // strobe levels; read strobe unused in read/write-line style
    wire rd_active = selected && (separate ? !read_strobe_n : write_strobe_n);
    wire wr_active = selected && (separate ? !write_strobe_n : !write_strobe_n);

    // state decodes
    wire in_idle  = (state == dup_pkg::DUP_IDLE);
    wire in_fetch = (state == dup_pkg::DUP_READ_FETCH);
    wire in_drive = (state == dup_pkg::DUP_READ_DRIVE);
    wire in_write = (state == dup_pkg::DUP_WRITE_OPEN);
    wire write_end = in_write && !wr_active;    // strobe rise or deselect closes it

    // next state
    always_comb
    begin
        next_state = state;
        case (state)
            dup_pkg::DUP_IDLE:
            begin
                // read wins if a glitchy host shows both
                if (rd_active)
                    next_state = dup_pkg::DUP_READ_FETCH;
                else if (wr_active)
                    next_state = dup_pkg::DUP_WRITE_OPEN;
            end
            dup_pkg::DUP_READ_FETCH:
            begin
                // a strobe too short to see the data just ends quietly
                next_state = rd_active ? dup_pkg::DUP_READ_DRIVE : dup_pkg::DUP_IDLE;
            end
            dup_pkg::DUP_READ_DRIVE:
            begin
                // host samples on the rising strobe, then we release
                if (!rd_active)
                    next_state = dup_pkg::DUP_IDLE;
            end
            dup_pkg::DUP_WRITE_OPEN:
            begin
                if (!wr_active)
                    next_state = dup_pkg::DUP_IDLE;
            end
            default: next_state = dup_pkg::DUP_IDLE;
        endcase
    end

    // handshake outputs straight from state
    assign reg_read = in_fetch;
    assign data_oe  = in_drive;

    // state register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state <= dup_pkg::DUP_IDLE;
        else
            state <= next_state;
    end

    // address and channel latched at the opening edge of an access
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            reg_addr    <= dup_pkg::ADDR_RESET;
            reg_channel <= dup_pkg::CHAN_A;
        end
        else if (in_idle && (rd_active || wr_active))
        begin
            reg_addr    <= addr;
            reg_channel <= access_chan;
        end
    end

    // read byte captured once, held while the strobe stays low
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            data_out <= dup_pkg::DATA_RESET;
        else if (in_fetch)
            data_out <= reg_rdata;
    end

    // write data taken when the strobe rises; bus still holds it then
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            reg_wdata <= dup_pkg::DATA_RESET;
            reg_write <= 1'b0;
        end
        else
        begin
            reg_write <= write_end;
            if (write_end)
                reg_wdata <= data_in;
        end
    end

    // device-wide request for the open-drain pin
    wire any_irq = channel_a_irq || channel_b_irq;

    // one pin driver per channel
    dup_irq_pin u_irq_a (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .separate_style (separate),
        .is_channel_a   (1'b1),
        .irq_in         (separate ? channel_a_irq : any_irq),
        .ioe            (channel_a_ioe),
        .pin_out        (channel_a_interrupt),
        .pin_oe         (channel_a_interrupt_oe),
        .general_out    (channel_a_general_output)
    );

    dup_irq_pin u_irq_b (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .separate_style (separate),
        .is_channel_a   (1'b0),
        .irq_in         (channel_b_irq),
        .ioe            (channel_b_ioe),
        .pin_out        (channel_b_interrupt),
        .pin_oe         (channel_b_interrupt_oe),
        .general_out    (channel_b_general_output)
    );

    // checks of the bus sequencing
    property p_read_start;
        @(posedge mclk) disable iff (!rst_n)
        (in_idle && rd_active) |=> (reg_read ##1 (data_oe || !$past(rd_active)));
    endproperty
    a_read_start: assert property (p_read_start) else $error("read not started");

    property p_read_data;
        @(posedge mclk) disable iff (!rst_n)
        (reg_read && rd_active) |=> (data_oe && data_out == $past(reg_rdata));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte wrong");

    property p_addr;
        @(posedge mclk) disable iff (!rst_n)
        (in_idle && (rd_active || wr_active)) |=> (reg_addr == $past(addr));
    endproperty
    a_addr: assert property (p_addr) else $error("register select not latched");

    property p_write_load;
        @(posedge mclk) disable iff (!rst_n)
        write_end |=> (reg_write && reg_wdata == $past(data_in) && !reg_read);
    endproperty
    a_write_load: assert property (p_write_load) else $error("write not loaded");

    property p_style_sep;
        @(posedge mclk) disable iff (!rst_n)
        (separate && in_idle && sep_sel && !read_strobe_n) |=> reg_read;
    endproperty
    a_style_sep: assert property (p_style_sep) else $error("separate read missed");

    property p_rd_ignored;
        @(posedge mclk) disable iff (!rst_n)
        (!separate && in_idle && rw_sel && !write_strobe_n) |=> (in_write && !reg_read);
    endproperty
    a_rd_ignored: assert property (p_rd_ignored) else $error("write line not a write");

    property p_dir_read;
        @(posedge mclk) disable iff (!rst_n)
        (!separate && in_idle && rw_sel && write_strobe_n) |=> reg_read;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction high not read");

    property p_sel_a;
        @(posedge mclk) disable iff (!rst_n)
        (separate && in_idle && !channel_a_select_n && channel_b_select_n
         && (rd_active || wr_active)) |=> (reg_channel == dup_pkg::CHAN_A);
    endproperty
    a_sel_a: assert property (p_sel_a) else $error("select a wrong channel");

    property p_sel_b;
        @(posedge mclk) disable iff (!rst_n)
        (separate && in_idle && channel_a_select_n && !channel_b_select_n
         && (rd_active || wr_active)) |=> (reg_channel == dup_pkg::CHAN_B);
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("select b wrong channel");

    property p_chip_sel;
        @(posedge mclk) disable iff (!rst_n)
        (!separate && channel_a_select_n && in_idle) |=> in_idle;
    endproperty
    a_chip_sel: assert property (p_chip_sel) else $error("access without chip select");

    property p_chan_bit;
        @(posedge mclk) disable iff (!rst_n)
        (!separate && in_idle && rw_sel) |=> (reg_channel == $past(channel_b_select_n));
    endproperty
    a_chan_bit: assert property (p_chan_bit) else $error("channel bit ignored");

    property p_no_sel;
        @(posedge mclk) disable iff (!rst_n)
        (!selected && !in_write) |=> (!data_oe && !reg_read && in_idle);
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("unselected access acted");

    c_read:  cover property (@(posedge mclk) disable iff (!rst_n) reg_read ##1 data_oe ##1 !data_oe);
    c_write: cover property (@(posedge mclk) disable iff (!rst_n) in_write ##1 reg_write);
    c_rw_b:  cover property (@(posedge mclk) disable iff (!rst_n)
                             !separate && reg_write && reg_channel);
endmodule : dup_host_port

/* File: testbench/dup_reg_model.sv */
// partner model: register store behind the host port, eight bytes per channel
`timescale 1ns/10ps
module dup_reg_model (
    input  wire logic       mclk,
    input  wire logic       reg_write,    // one-cycle load request
    input  wire logic       reg_channel,  // 0 a, 1 b
    input  wire logic [2:0] reg_addr,     // register select
    input  wire logic [7:0] reg_wdata,    // byte to load
    output logic      [7:0] reg_rdata     // byte answered
);
    logic [7:0] mem [16];                 // channel bit above the select
    // answer at once, so the byte is valid in the fetch cycle
    assign reg_rdata = mem[{reg_channel, reg_addr}];
    // load on the request pulse; unwritten places stay unknown on purpose
    always_ff @(posedge mclk)
    begin
        if (reg_write)
            mem[{reg_channel, reg_addr}] <= reg_wdata;
    end
endmodule : dup_reg_model

/* File: testbench/dual_uart_host_bus_port_test.sv */
// self-checking bench for the host bus port, bench acting as host
`timescale 1ns/10ps
module dual_uart_host_bus_port_test;
    logic       mclk, rst_n, bus_style, rd_n, wr_n, a_n, b_n;  // clock and pins
    logic       host_en, irq_a, irq_b, ioe_a, ioe_b;           // host drive, irq side
    logic [2:0] addr;                                          // register select
    logic [7:0] host_dq, bus, data_out, reg_rdata, reg_wdata;  // data paths
    logic [2:0] reg_addr;                                      // internal select
    logic       data_oe, reg_read, reg_write, reg_channel;     // internal strobes
    logic       int_a, oe_a, int_b, oe_b, gen_a, gen_b;        // irq pins
    int         n_mismatch, check_count;                       // verdict counters
    // resolved data bus; a released bus shows the inverse of the last byte
    assign bus = data_oe ? data_out : (host_en ? host_dq : ~host_dq);
    dup_host_port uut (.mclk(mclk), .rst_n(rst_n), .bus_style(bus_style), .addr(addr),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .channel_a_select_n(a_n),
        .channel_b_select_n(b_n), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
        .reg_read(reg_read), .reg_write(reg_write), .reg_channel(reg_channel),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .channel_a_irq(irq_a), .channel_b_irq(irq_b), .channel_a_ioe(ioe_a),
        .channel_b_ioe(ioe_b), .channel_a_interrupt(int_a), .channel_a_interrupt_oe(oe_a),
        .channel_b_interrupt(int_b), .channel_b_interrupt_oe(oe_b),
        .channel_a_general_output(gen_a), .channel_b_general_output(gen_b));
    dup_reg_model model (.mclk(mclk), .reg_write(reg_write), .reg_channel(reg_channel),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one bus access; strobes held, released, then data held one more cycle
    task acc(input logic an, bn, rn, wn, input logic [2:0] ad, input logic [7:0] wd,
             output logic [7:0] rd, output logic oe);
        @(negedge mclk);
        a_n = an;
        b_n = bn;
        rd_n = rn;
        wr_n = wn;
        addr = ad;
        host_dq = wd;
        host_en = ~wn;
        repeat (4) @(negedge mclk);
        rd = bus;
        oe = data_oe;
        a_n = 1'b1;
        b_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge mclk);
        host_en = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : acc
    // separate strobes: every select of both channels, refused accesses
    task t_sep;
        logic [7:0] d;
        logic       oe;
        bus_style = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 1'b1, 1'b1, 1'b0, 3'(i), 8'(8'h10 + i), d, oe);
            acc(1'b1, 1'b0, 1'b1, 1'b0, 3'(i), 8'(8'h80 + i), d, oe);
        end
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 1'b1, 1'b0, 1'b1, 3'(i), 8'h00, d, oe);
            chk(d, 8'(8'h10 + i));
            chk(8'(oe), 8'h01);
            acc(1'b1, 1'b0, 1'b0, 1'b1, 3'(i), 8'h00, d, oe);
            chk(d, 8'(8'h80 + i));
        end
        chk(8'(data_oe), 8'h00);
        acc(1'b1, 1'b1, 1'b0, 1'b1, 3'h3, 8'h00, d, oe);
        chk(8'(oe), 8'h00);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 8'h00, d, oe);
        chk(8'(oe), 8'h00);
        acc(1'b1, 1'b1, 1'b1, 1'b0, 3'h3, 8'hEE, d, oe);
        acc(1'b0, 1'b1, 1'b0, 1'b1, 3'h3, 8'h00, d, oe);
        chk(d, 8'h13);
        $display("test separate strobes done");
    endtask : t_sep
    // read/write line style with the read strobe held low except in the channel b register 5 read
    task t_rw;
        logic [7:0] d;
        logic       oe;
        bus_style = 1'b0;
        acc(1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 8'h66, d, oe);
        acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h1, 8'h99, d, oe);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 3'h1, 8'h00, d, oe);
        chk(d, 8'h66);
        acc(1'b0, 1'b1, 1'b0, 1'b1, 3'h1, 8'h00, d, oe);
        chk(d, 8'h99);
        acc(1'b0, 1'b1, 1'b1, 1'b1, 3'h5, 8'h00, d, oe);
        chk(d, 8'h85);
        acc(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 8'h00, d, oe);
        chk(8'(oe), 8'h00);
        $display("test read/write line done");
    endtask : t_rw
    // interrupt pins for each style, enable and request level
    task t_irq;
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 4; k++)
            begin
                @(negedge mclk);
                bus_style = s[0];
                ioe_a = k[0];
                ioe_b = k[0];
                irq_a = k[1];
                irq_b = k[0] ^ k[1];
                repeat (2) @(negedge mclk);
                // concatenation keeps the inversion one bit wide before widening
                chk(8'(gen_a), {7'h00, ~k[0]});
                chk(8'(gen_b), {7'h00, ~k[0]});
                if (s == 1)
                begin
                    chk(8'({int_a, oe_a}), 8'({k[1], k[0]}));
                    chk(8'({int_b, oe_b}), 8'({k[0] ^ k[1], k[0]}));
                end
                else
                begin
                    chk(8'({int_a, oe_a}), 8'({1'b0, k[1] | k[0]}));
                    chk(8'({int_b, oe_b}), 8'h01);
                end
            end
        $display("test interrupt pins done");
    endtask : t_irq
    // verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // watchdog, about thirteen times the expected run
    initial
    begin
        #50000;
        n_mismatch++;
        report_and_stop;
    end
    // main sequence
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        {rst_n, bus_style, irq_a, irq_b, ioe_a, ioe_b, host_en} = 7'h00;
        {rd_n, wr_n, a_n, b_n} = 4'hF;
        addr = 3'h0;
        host_dq = 8'h00;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        t_sep;
        t_rw;
        t_irq;
        report_and_stop;
    end
endmodule : dual_uart_host_bus_port_test
